// >>> rtl/nis_pkg.sv
// Constants, types and decode helpers of the nested interrupt servicing block
package nis_pkg;
   // ==========================================
   // Sizes
   localparam int NSRC   = 8;
   localparam int NLVL   = 8;
   localparam int ADDR_W = 8;
   // ==========================================
   // Register offsets
   localparam logic [7:0] OFS_CTRL0    = 8'h00;
   localparam logic [7:0] OFS_EVT_STAT = 8'h20;
   localparam logic [7:0] OFS_EVT_MASK = 8'h24;
   localparam logic [7:0] OFS_STATE    = 8'h28;
   localparam logic [7:0] OFS_DBG_PC   = 8'h2C;
   localparam logic [7:0] OFS_DBG_PSW  = 8'h30;
   localparam logic [7:0] OFS_EXC_PC   = 8'h34;
   localparam logic [7:0] OFS_EXC_PSW  = 8'h38;
   // ==========================================
   // Field positions and reset values
   localparam int CTL_MASK_BIT = 6;
   localparam int CTL_PEND_BIT = 7;
   localparam int CTL_EXT_BIT  = 8;
   localparam logic [2:0] PRIO_RST = 3'h7;
   localparam logic       MASK_RST = 1'b1;
   localparam int EVT_ACK  = 0;
   localparam int EVT_NEST = 1;
   localparam int EVT_DBG  = 2;
   localparam int EVT_NMI  = 3;
   localparam int EVT_W    = 4;
   localparam int ST_NMI_BIT = 8;
   localparam int ST_DBG_BIT = 9;
   localparam int INTERRUPT_DISABLE_FLAG_BIT = 5;
   localparam int PSW_EP_BIT = 6;
   localparam logic [31:0] PSW_NP_M = 32'h0000_0080;
   localparam logic [31:0] PSW_EP_M = 32'h0000_0040;
   localparam logic [31:0] INTERRUPT_DISABLE_FLAG_M = 32'h0000_0020;
   localparam logic [4:0]  SYSREG_PSW = 5'h05;
   localparam logic [31:0] DBG_VEC = 32'h0000_0060;
   localparam logic [3:0]  LVL_NONE = 4'h8;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // ==========================================
   // Timing: least response time, in clocks
   localparam int RESP_CLKS = 4;
   // ==========================================
   // Types
   typedef enum logic [3:0] {
      OP_OTHER, OP_DEBUG_TRAP_INSTR, OP_DEBUG_RETURN_INSTR, OP_INTERRUPT_RETURN_INSTR, OP_EI, OP_DI,
      OP_SYSREG_LOAD_INSTR, OP_STORE, OP_BITOP, OP_BITTEST
   } nis_op_t;
   typedef enum logic [2:0] {
      TGT_OTHER, TGT_PROTECT_A, TGT_PROTECT_B, TGT_INT_CTRL,
      TGT_MASK_GRP, TGT_PWR_SAVE, TGT_MEM_SIZE
   } nis_tgt_t;
   typedef struct packed {
      logic       valid;
      nis_op_t    op;
      logic [4:0] sysreg;
      nis_tgt_t   tgt;
   } nis_instr_t;
   typedef struct packed {
      logic        valid;
      logic [31:0] pc;
      logic [31:0] processor_status_word;
   } nis_redir_t;
   // ==========================================
   // Instructions that hold off acknowledgment until the next one
   function automatic logic nis_blocks(input nis_instr_t ins);
      logic intreg;
      intreg = ins.tgt inside {TGT_INT_CTRL, TGT_MASK_GRP, TGT_PWR_SAVE, TGT_MEM_SIZE};
      return ins.op inside {OP_EI, OP_DI}
         || (ins.op == OP_SYSREG_LOAD_INSTR && ins.sysreg == SYSREG_PSW)
         || (ins.op == OP_STORE && ins.tgt inside {TGT_PROTECT_A, TGT_PROTECT_B})
         || (ins.op inside {OP_STORE, OP_BITOP} && intreg);
   endfunction
endpackage

// >>> rtl/nis_ctrl.sv
// Nested interrupt servicing control with AXI4-Lite register access
//
// How it works
// [R1] Debug return reloads pc and status from saves
// [R2] Debug saves accessible only inside debug window
// [R3] Strictly higher priority preempts current servicing
// [R4] Lower or equal priority stays pending
// [R5] Maskable nesting only while interrupt disable clear
// [R6] Handler software saves exception pc/status first
// [R7] Eight priority levels per source, zero highest
// [R8] Reset: all masked, priority seven
// [R9] Suspended or pending resumes after interrupt return
// [R10] No maskable acknowledge during NMI servicing
// [R11] Response time at least four clocks; nmi_ack can come two clocks after nmi_req
// [R12] Sources space requests four clocks apart
// [R13] No acknowledge right after blocking instruction
// [R14] Blocking instruction set decoded from instruction
// [R15] External pin selection suppresses shared sources
// [R16] Debug trap saves, sets flags, jumps 60H
// [R17] Interrupt return reloads exception saved registers
// [R18] Equal priority ties go to lowest index
// [R19] Pending latched until acknowledged or cleared
//
// The address map and the AXI4-Lite register port are this design's own decisions.
module nis_ctrl
   import nis_pkg::*;
#(
   parameter logic [31:0] MVEC_BASE = 32'h0000_0080,
   parameter logic [31:0] NMI_VEC   = 32'h0000_0010
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [NSRC-1:0]   src_req,
   input  wire logic [NSRC-1:0]   ext_irq_input,
   input  wire logic              nmi_req,
   input  wire nis_instr_t        instr,
   input  wire logic [31:0]       cur_pc,
   input  wire logic [31:0]       cur_psw,
   output nis_redir_t             redir,
   output logic                   ack,
   output logic [2:0]             ack_idx,
   output logic                   nmi_ack,
   output logic                   irq
);
   localparam int AGE_W = $clog2(RESP_CLKS);
   localparam logic [AGE_W-1:0] AGE_MAX = AGE_W'(RESP_CLKS - 1);

   // ==========================================
   // Storage
   logic [2:0]       prio_r [NSRC];
   logic [NSRC-1:0]  mask_r;
   logic [NSRC-1:0]  ext_sel_r;
   logic [NSRC-1:0]  pend_r;
   logic [AGE_W-1:0] age_r [NSRC];
   logic [NSRC-1:0]  ext_sync1_r;
   logic [NSRC-1:0]  ext_sync2_r;
   logic [NLVL-1:0]  insvc_r;
   logic             nmi_pend_r;
   logic             nmi_active_r;
   logic             block_win_r;
   logic             dbg_win_r;
   logic [AGE_W-1:0] gap_r;
   logic [31:0]      dbg_pc_r;
   logic [31:0]      dbg_psw_r;
   logic [31:0]      exc_pc_r;
   logic [31:0]      exc_psw_r;
   logic [EVT_W-1:0] evt_stat_r;
   logic [EVT_W-1:0] evt_mask_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0]      w_data_r;
   logic [3:0]       w_strb_r;
   logic             aw_full_r;
   logic             w_full_r;
   nis_redir_t       redir_r;
   logic             ack_r;
   logic [2:0]       ack_idx_r;
   logic             nmi_ack_r;
   logic             irq_r;
   logic             awready_r;
   logic             wready_r;
   logic             bvalid_r;
   logic [1:0]       bresp_r;
   logic             arready_r;
   logic             rvalid_r;
   logic [31:0]      rdata_r;
   logic [1:0]       rresp_r;

   // ==========================================
   // Address decode
   function automatic logic ctrl_hit(input logic [ADDR_W-1:0] a);
      return a[7:5] == 3'h0 && a[1:0] == 2'h0;
   endfunction

   function automatic logic addr_known(input logic [ADDR_W-1:0] a);
      return ctrl_hit(a) || a inside {OFS_EVT_STAT, OFS_EVT_MASK, OFS_STATE, OFS_DBG_PC,
                                      OFS_DBG_PSW, OFS_EXC_PC, OFS_EXC_PSW};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   logic wr_fire;
   logic rd_fire;
   logic [2:0] wr_idx;
   assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
   assign rd_fire = s_axi_arvalid && arready_r;
   assign wr_idx  = aw_addr_r[4:2];

   // ==========================================
   // Request sources and pending latches
   logic [NSRC-1:0] req_eff;
   logic [NSRC-1:0] sw_clr;
   logic [NSRC-1:0] ack_clr;
   logic            mack_fire;
   logic            nmi_fire;
   logic [2:0]      best_idx;
   logic [3:0]      best_prio;
   logic            best_ok;
   logic [3:0]      cur_level;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync1_r <= '0;
         ext_sync2_r <= '0;
      end else begin
         ext_sync1_r <= ext_irq_input;
         ext_sync2_r <= ext_sync1_r;
      end
   end

   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         req_eff[i] = ext_sel_r[i] ? ext_sync2_r[i] : src_req[i]; // [R15]
         sw_clr[i]  = wr_fire && ctrl_hit(aw_addr_r) && wr_idx == 3'(i) && w_strb_r[0]
                      && !w_data_r[CTL_PEND_BIT];
         ack_clr[i] = mack_fire && best_idx == 3'(i);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_r <= '0;
         for (int i = 0; i < NSRC; i++) begin
            age_r[i] <= '0;
         end
      end else begin
         // Set wins over acknowledge and software clear
         pend_r <= req_eff | (pend_r & ~(ack_clr | sw_clr)); // [R19]
         for (int i = 0; i < NSRC; i++) begin
            // Age gates the least response time; sources keep spacing [R12]
            if (!pend_r[i] || ack_clr[i] || sw_clr[i]) begin
               age_r[i] <= '0;
            end else if (age_r[i] != AGE_MAX) begin
               age_r[i] <= age_r[i] + 1'b1; // [R11]
            end
         end
      end
   end

   // ==========================================
   // Arbitration
   always_comb begin
      best_ok   = 1'b0;
      best_idx  = 3'h0;
      best_prio = LVL_NONE;
      for (int i = 0; i < NSRC; i++) begin
         // Strict compare keeps the lowest index on ties
         if (pend_r[i] && !mask_r[i] && age_r[i] == AGE_MAX
             && {1'b0, prio_r[i]} < best_prio) begin // [R18]
            best_ok   = 1'b1;
            best_idx  = 3'(i);
            best_prio = {1'b0, prio_r[i]}; // [R7]
         end
      end
      cur_level = LVL_NONE;
      for (int l = NLVL - 1; l >= 0; l--) begin
         if (insvc_r[l]) begin
            cur_level = 4'(l);
         end
      end
   end

   logic cpu_evt;
   logic blk_now;
   logic ack_gate;
   logic is_trap;
   logic is_debug_return_instr;
   logic is_interrupt_return_instr;
   assign is_trap  = instr.valid && instr.op == OP_DEBUG_TRAP_INSTR;
   assign is_debug_return_instr = instr.valid && instr.op == OP_DEBUG_RETURN_INSTR;
   assign is_interrupt_return_instr  = instr.valid && instr.op == OP_INTERRUPT_RETURN_INSTR;
   assign cpu_evt  = is_trap || is_debug_return_instr || is_interrupt_return_instr;
   assign blk_now  = instr.valid && nis_blocks(instr); // [R14]
   assign ack_gate = !cpu_evt && gap_r == '0 && !block_win_r && !blk_now; // [R13]
   assign nmi_fire = ack_gate && nmi_pend_r && !nmi_active_r;
   assign mack_fire = ack_gate && !nmi_fire && best_ok
                      && best_prio < cur_level // [R3] [R4]
                      && !cur_psw[INTERRUPT_DISABLE_FLAG_BIT] // [R5]
                      && !nmi_active_r; // [R10]

   // ==========================================
   // Servicing state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         insvc_r      <= '0;
         nmi_pend_r   <= 1'b0;
         nmi_active_r <= 1'b0;
         block_win_r  <= 1'b0;
         gap_r        <= '0;
      end else begin
         nmi_pend_r <= nmi_req | (nmi_pend_r & ~nmi_fire);
         if (nmi_fire) begin
            nmi_active_r <= 1'b1;
         end else if (is_interrupt_return_instr && nmi_active_r) begin
            nmi_active_r <= 1'b0; // [R10]
         end
         if (mack_fire) begin
            insvc_r[best_prio[2:0]] <= 1'b1;
         end else if (is_interrupt_return_instr && !nmi_active_r && !cur_psw[PSW_EP_BIT]
                      && cur_level != LVL_NONE) begin
            insvc_r[cur_level[2:0]] <= 1'b0; // [R9]
         end
         if (blk_now) begin
            block_win_r <= 1'b1; // [R13]
         end else if (instr.valid) begin
            block_win_r <= 1'b0;
         end
         // Let the pipeline take the new status before the next acknowledge
         if (cpu_evt || nmi_fire || mack_fire) begin
            gap_r <= AGE_MAX;
         end else if (gap_r != '0) begin
            gap_r <= gap_r - 1'b1;
         end
      end
   end

   // ==========================================
   // Save registers and redirect
   logic dbg_wr_pc;
   logic dbg_wr_psw;
   assign dbg_wr_pc  = wr_fire && dbg_win_r && aw_addr_r == OFS_DBG_PC; // [R2]
   assign dbg_wr_psw = wr_fire && dbg_win_r && aw_addr_r == OFS_DBG_PSW; // [R2]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         redir_r   <= '0;
         dbg_win_r <= 1'b0;
         dbg_pc_r  <= '0;
         dbg_psw_r <= '0;
         exc_pc_r  <= '0;
         exc_psw_r <= '0;
      end else begin
         redir_r.valid <= 1'b0;
         if (is_trap) begin
            dbg_pc_r  <= cur_pc; // [R16]
            dbg_psw_r <= cur_psw;
            dbg_win_r <= 1'b1;
            redir_r   <= '{1'b1, DBG_VEC, cur_psw | PSW_NP_M | PSW_EP_M | INTERRUPT_DISABLE_FLAG_M};
         end else if (is_debug_return_instr) begin
            dbg_win_r <= 1'b0;
            redir_r   <= '{1'b1, dbg_pc_r, dbg_psw_r}; // [R1]
         end else if (is_interrupt_return_instr) begin
            redir_r   <= '{1'b1, exc_pc_r, exc_psw_r}; // [R17]
         end else if (nmi_fire || mack_fire) begin
            exc_pc_r  <= cur_pc;
            exc_psw_r <= cur_psw;
            redir_r.valid <= 1'b1;
            redir_r.pc    <= nmi_fire ? NMI_VEC : MVEC_BASE + {25'h0, best_idx, 4'h0};
            redir_r.processor_status_word   <= cur_psw | INTERRUPT_DISABLE_FLAG_M | (nmi_fire ? PSW_NP_M : 32'h0000_0000);
         end else begin
            if (dbg_wr_pc) begin
               dbg_pc_r <= merge(dbg_pc_r, w_data_r, w_strb_r);
            end
            if (dbg_wr_psw) begin
               dbg_psw_r <= merge(dbg_psw_r, w_data_r, w_strb_r);
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ack_r     <= 1'b0;
         ack_idx_r <= 3'h0;
         nmi_ack_r <= 1'b0;
      end else begin
         ack_r     <= mack_fire;
         nmi_ack_r <= nmi_fire;
         if (mack_fire) begin
            ack_idx_r <= best_idx;
         end
      end
   end

   // ==========================================
   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r     <= {NSRC{MASK_RST}}; // [R8]
         ext_sel_r  <= '0;
         evt_mask_r <= '0;
         for (int i = 0; i < NSRC; i++) begin
            prio_r[i] <= PRIO_RST; // [R8]
         end
      end else if (wr_fire) begin
         if (ctrl_hit(aw_addr_r)) begin
            if (w_strb_r[0]) begin
               prio_r[wr_idx] <= w_data_r[2:0]; // [R7]
               mask_r[wr_idx] <= w_data_r[CTL_MASK_BIT];
            end
            if (w_strb_r[1]) begin
               ext_sel_r[wr_idx] <= w_data_r[CTL_EXT_BIT];
            end
         end else if (aw_addr_r == OFS_EVT_MASK && w_strb_r[0]) begin
            evt_mask_r <= w_data_r[EVT_W-1:0];
         end
      end
   end

   // ==========================================
   // Event status and interrupt output
   logic [EVT_W-1:0] evt_set;
   logic             evt_rd_clr;
   assign evt_set[EVT_ACK]  = mack_fire;
   assign evt_set[EVT_NEST] = mack_fire && cur_level != LVL_NONE;
   assign evt_set[EVT_DBG]  = is_trap;
   assign evt_set[EVT_NMI]  = nmi_fire;
   assign evt_rd_clr = rd_fire && s_axi_araddr == OFS_EVT_STAT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_stat_r <= '0;
         irq_r      <= 1'b0;
      end else begin
         evt_stat_r <= evt_set | (evt_stat_r & ~{EVT_W{evt_rd_clr}});
         irq_r      <= |(evt_stat_r & evt_mask_r);
      end
   end

   // ==========================================
   // AXI4-Lite slave
   logic [31:0] rd_data;
   logic [2:0]  rd_idx;
   assign rd_idx = s_axi_araddr[4:2];

   always_comb begin
      rd_data = 32'h0000_0000;
      if (ctrl_hit(s_axi_araddr)) begin
         rd_data[2:0]          = prio_r[rd_idx];
         rd_data[CTL_MASK_BIT] = mask_r[rd_idx];
         rd_data[CTL_PEND_BIT] = pend_r[rd_idx];
         rd_data[CTL_EXT_BIT]  = ext_sel_r[rd_idx];
      end else begin
         case (s_axi_araddr)
            OFS_EVT_STAT: rd_data[EVT_W-1:0] = evt_stat_r;
            OFS_EVT_MASK: rd_data[EVT_W-1:0] = evt_mask_r;
            OFS_STATE: begin
               rd_data[NLVL-1:0]  = insvc_r;
               rd_data[ST_NMI_BIT] = nmi_active_r;
               rd_data[ST_DBG_BIT] = dbg_win_r;
            end
            OFS_DBG_PC:  rd_data = dbg_win_r ? dbg_pc_r : 32'h0000_0000; // [R2]
            OFS_DBG_PSW: rd_data = dbg_win_r ? dbg_psw_r : 32'h0000_0000; // [R2]
            OFS_EXC_PC:  rd_data = exc_pc_r;
            OFS_EXC_PSW: rd_data = exc_psw_r;
            default:     rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= '0;
         w_strb_r  <= '0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            aw_addr_r <= s_axi_awaddr;
            aw_full_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            w_full_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (wr_fire) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= addr_known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
      end else begin
         if (rd_fire) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_data;
            rresp_r   <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign redir         = redir_r;
   assign ack           = ack_r;
   assign ack_idx       = ack_idx_r;
   assign nmi_ack       = nmi_ack_r;
   assign irq           = irq_r;

   // ==========================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_new_req2;
      req_eff[2] && !pend_r[2];
   endsequence
   sequence s_trap;
      is_trap;
   endsequence

   a_reset_masked: assert property ($past(aresetn) == 1'b0 |-> &mask_r && prio_r[3] == 3'h7) // [R8]
      else $error("sources not masked at priority seven after reset");
   a_id_blocks: assert property (cur_psw[INTERRUPT_DISABLE_FLAG_BIT] |=> !ack_r) // [R5]
      else $error("maskable acknowledge with interrupt disable set");
   a_nmi_holds: assert property (nmi_active_r |-> ##1 !ack_r) // [R10]
      else $error("maskable acknowledge during nmi servicing");
   a_block_window: assert property (blk_now |=> !ack_r && !nmi_ack_r) // [R13]
      else $error("acknowledge after blocking instruction");
   a_resp_least: assert property (s_new_req2 |-> ##1 (!(ack_r && ack_idx_r == 3'h2))[*4]) // [R11]
      else $error("acknowledge earlier than four clocks");
   a_prio_strict: assert property (ack_r |-> $past(best_prio) < $past(cur_level)) // [R3]
      else $error("acknowledge without strictly higher priority");
   a_debug_return_instr_load: assert property (is_debug_return_instr |=> redir_r.valid && redir_r.pc == $past(dbg_pc_r)
                                  && redir_r.processor_status_word == $past(dbg_psw_r)) // [R1]
      else $error("debug return did not reload saved pc and status");
   a_trap_vector: assert property (s_trap |=> redir_r.valid && redir_r.pc == DBG_VEC
                                   && dbg_pc_r == $past(cur_pc) && dbg_win_r) // [R16]
      else $error("debug trap did not save and jump");
   a_interrupt_return_instr_load: assert property (is_interrupt_return_instr |=> redir_r.pc == $past(exc_pc_r)) // [R17]
      else $error("interrupt return did not reload exception saves");
   a_pend_kept: assert property (pend_r[4] && !ack_clr[4] && !sw_clr[4] |=> pend_r[4]) // [R19]
      else $error("pending request lost");
endmodule

// >>> sim/nis_src_model.sv
// Peripheral request source model with enforced request spacing
module nis_src_model
   import nis_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic            fire,
   input  wire logic [2:0]      fire_idx,
   output logic [NSRC-1:0]      src_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] gap_r;
   // ==========================================
   // One-cycle request pulse, then quiet for the spacing time
   always_ff @(posedge aclk) begin
      src_req <= '0;
      if (!aresetn) begin
         gap_r <= 3'h0;
      end else if (gap_r != 3'h0) begin
         gap_r <= gap_r - 3'h1;
      end else if (fire) begin
         src_req <= NSRC'(1) << fire_idx;
         gap_r   <= 3'h3;
      end
   end
endmodule

// >>> sim/tb.sv
// Self-checking bench of the nested interrupt servicing block
module tb;
   import nis_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} nis_row_t;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, nmi_req, ack, nmi_ack, irq, fire;
   logic [7:0]      s_axi_awaddr, s_axi_araddr;
   logic [31:0]     s_axi_wdata, s_axi_rdata, cur_pc, cur_psw, d;
   logic [3:0]      s_axi_wstrb;
   logic [1:0]      s_axi_bresp, s_axi_rresp, r;
   logic [NSRC-1:0] src_req, ext_irq_input;
   logic [2:0]      ack_idx, fire_idx;
   nis_instr_t      instr;
   nis_redir_t      redir;
   int              fail_count, n_compared, c;
   nis_row_t        rows [4] = '{'{8'h04, 32'h0000_0005, 32'h0000_0005},
      '{OFS_STATE, 32'hFFFF_FFFF, 32'h0}, '{OFS_DBG_PC, 32'h1234_5678, 32'h0},
      '{8'h0C, 32'h0000_00C2, 32'h0000_0042}};
   localparam logic [31:0] MVEC_BASE_EXP = 32'h0000_0080;
   nis_ctrl u_nis_ctrl (.*);
   nis_src_model u_nis_src_model (.*);
   // ==========================================
   // Clock and helpers
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic report_and_stop();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      int n;
      s_axi_awaddr <= a; s_axi_wdata <= w; s_axi_bready <= 1'b1;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      tmo(n);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0;
      tmo(n);
   endtask
   task automatic wack(output int k);
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         #1;
         if (ack === 1'b1) break;
      end
   endtask
   task automatic raise(input logic [2:0] i, output int k);
      fire_idx <= i; fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      wack(k);
   endtask
   task automatic op(input nis_op_t o);
      int n;
      instr <= '{1'b1, o, 5'h0, TGT_OTHER};
      @(posedge aclk);
      instr <= '0;
      for (n = 0; n < 40; n++) begin
         #1;
         if (redir.valid === 1'b1) break;
         @(posedge aclk);
      end
      tmo(n);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = '0; s_axi_araddr = '0;
      s_axi_wdata = '0; s_axi_wstrb = 4'hF; nmi_req = 1'b0; ext_irq_input = '0;
      cur_pc = 32'h0000_0200; cur_psw = '0; instr = '0; fire = 1'b0; fire_idx = '0;
      fail_count = 0; n_compared = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CTRL0); chk("ctrl0_reset", 32'h0000_0047, d);
      rd(8'h40); chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      wr(8'h40, 32'h0); chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a); chk("row_readback", rows[i].e, d);
      end
      wr(OFS_EVT_MASK, 32'h0000_000F); wr(8'h08, 32'h0000_0003);
      wr(8'h04, 32'h0000_0001); wr(8'h10, 32'h0000_0005);
      raise(3'h2, c); chk("resp_time", 4, c);
      chk("ack_vec", MVEC_BASE_EXP + 32'h20, redir.pc);
      repeat (2) @(posedge aclk);
      chk("irq_set", 1, irq);
      rd(OFS_EVT_STAT); chk("evt_stat", 32'h1, d & 32'h1);
      repeat (2) @(posedge aclk);
      chk("irq_clear", 0, irq);
      raise(3'h4, c); chk("lower_held", 40, c);
      rd(OFS_EXC_PC); chk("exc_saved", 32'h0000_0200, d);
      instr <= '{1'b1, OP_DI, 5'h0, TGT_OTHER};
      raise(3'h1, c); chk("blocked", 40, c);
      instr <= '{1'b1, OP_BITTEST, 5'h0, TGT_INT_CTRL};
      @(posedge aclk);
      instr <= '0;
      wack(c);
      tmo(c);
      chk("nested_idx", 1, ack_idx);
      op(OP_INTERRUPT_RETURN_INSTR);
      chk("interrupt_return_instr_pc", 32'h0000_0200, redir.pc);
      wack(c); chk("still_held", 40, c);
      op(OP_INTERRUPT_RETURN_INSTR);
      wack(c);
      tmo(c);
      chk("resumed_idx", 4, ack_idx);
      wr(8'h14, 32'h0000_0100);
      raise(3'h5, c); chk("ext_sel_quiet", 40, c);
      cur_pc <= 32'h0000_1234;
      op(OP_DEBUG_TRAP_INSTR); chk("dbg_vec", DBG_VEC, redir.pc);
      chk("dbg_psw", PSW_NP_M | PSW_EP_M | INTERRUPT_DISABLE_FLAG_M, redir.processor_status_word);
      rd(OFS_DBG_PC); chk("dbg_pc", 32'h0000_1234, d);
      cur_pc <= 32'h0000_0000;
      op(OP_DEBUG_RETURN_INSTR); chk("dbg_ret", 32'h0000_1234, redir.pc);
      // Interrupt disable set holds a higher-priority request
      cur_psw <= INTERRUPT_DISABLE_FLAG_M;
      raise(3'h1, c); chk("id_held", 40, c);
      cur_psw <= '0;
      wack(c);
      tmo(c);
      chk("id_clear_idx", 1, ack_idx);
      // Non-maskable servicing holds maskable requests until return
      nmi_req <= 1'b1;
      @(posedge aclk);
      nmi_req <= 1'b0;
      for (c = 0; c < 40 && nmi_ack !== 1'b1; c++) begin
         @(posedge aclk);
         #1;
      end
      tmo(c);
      chk("nmi_ack", 1, nmi_ack);
      ext_irq_input <= 8'h20;
      wack(c); chk("nmi_holds", 40, c);
      op(OP_INTERRUPT_RETURN_INSTR);
      wack(c);
      tmo(c);
      chk("ext_idx", 5, ack_idx);
      report_and_stop();
   end
endmodule
